// ---- common/cag_pkg.sv ----
// Purpose: Shared constants and types for the address generation block.
// Assumes: 16-bit address space, 8-bit instruction fields.
// Notes:   The vector table, RAM and SFR bounds and the table index and short bit positions live here.
package cag_pkg;

   // ************************************************************
   // Widths and field positions
   // ************************************************************
   localparam int ADDR_W        = 16;   // Width of every address.
   localparam int BYTE_W        = 8;    // Width of an instruction byte field.
   localparam int VEC_IDX_LSB   = 1;    // Lowest opcode bit of the table index.
   localparam int VEC_IDX_MSB   = 5;    // Highest opcode bit of the table index.
   localparam int SADDR_BIT8    = 8;    // Address bit steered by the short field.

   // ************************************************************
   // Address map values
   // ************************************************************
   localparam logic [15:0] VEC_TABLE_BASE = 16'h0040;  // First vector table byte.
   localparam logic [15:0] VEC_TABLE_LAST = 16'h007F;  // Last vector table byte.
   localparam logic [6:0]  SADDR_UPPER    = 7'h7F;     // Bits 15..9 of a short address.
   localparam logic [7:0]  SADDR_SPLIT    = 8'h20;     // Fields below this land in the SFR part.
   localparam logic [7:0]  SFR_UPPER      = 8'hFF;     // Upper byte of an SFR address.
   localparam logic [15:0] RAM_LO         = 16'hFE20;  // First internal high-speed RAM byte.
   localparam logic [15:0] RAM_HI         = 16'hFEFF;  // Last internal high-speed RAM byte.
   localparam logic [15:0] SFR_LO         = 16'hFF00;  // First special register byte.
   localparam logic [15:0] SFR_HI         = 16'hFFFF;  // Last special register byte.
   localparam logic [15:0] ZERO16         = 16'h0000;  // Reset value of address outputs.

   // ************************************************************
   // Request modes and controller states
   // ************************************************************
   typedef enum logic [3:0] {
      MODE_BR_IMM,     // Absolute call or branch to the immediate word.
      MODE_VEC_CALL,   // Vector table call.
      MODE_BR_ACC,     // Branch to the accumulator pair.
      MODE_BR_REL,     // Relative branch by the displacement byte.
      MODE_DIRECT,     // Operand at the immediate word.
      MODE_SHORT,      // Operand in the short direct window.
      MODE_SFR,        // Operand in the special register page.
      MODE_REG,        // Register or register pair operand.
      MODE_IND_PAIR,   // Operand at the indirect pair.
      MODE_IND_BASE,   // Operand at the base pair.
      MODE_BASED,      // Operand at base pair plus byte offset.
      MODE_PUSH,       // Stack write below the stack pointer.
      MODE_POP         // Stack read at the stack pointer.
   } cag_mode_type;

   typedef enum logic [0:0] {
      ST_IDLE,         // Ready for a request.
      ST_VEC_WAIT      // Waiting for the vector table word.
   } cag_state_type;

endpackage : cag_pkg

// ---- common/cag_ea_if.sv ----
// Purpose: Carries operand address inputs and results between the
//          controller and the operand address calculator.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   The calc modport computes, the ctrl modport supplies and reads.
interface cag_ea_if;
   import cag_pkg::*;

   cag_mode_type mode;           // Operand addressing mode.
   logic [7:0]   field8;         // Byte field from the instruction.
   logic [15:0]  imm16;          // Immediate word from the instruction.
   logic [15:0]  indirect_pair;  // Indirect pair contents.
   logic [15:0]  base_pair;      // Base pair contents.
   logic [15:0]  stack_ptr;      // Stack pointer contents.
   logic         word_op;        // Operand is 16 bits wide.
   logic [15:0]  ea;             // Computed effective address.
   logic         in_ram;         // Address lies in high-speed RAM.
   logic         in_sfr;         // Address lies in the SFR page.
   logic         misaligned;     // Word short operand on an odd address.
   logic         stack_fault;    // Stack address outside high-speed RAM.

   modport calc (
      input  mode, field8, imm16, indirect_pair, base_pair, stack_ptr, word_op,
      output ea, in_ram, in_sfr, misaligned, stack_fault
   );
   modport ctrl (
      output mode, field8, imm16, indirect_pair, base_pair, stack_ptr, word_op,
      input  ea, in_ram, in_sfr, misaligned, stack_fault
   );
endinterface : cag_ea_if

// ---- src/cag_ea_calc.sv ----
// Purpose: Combinational operand effective address calculation.
// Assumes: Inputs are stable for the cycle in which the result is used.
// Notes:   No state; the controller registers the results.
module cag_ea_calc (
   // Link to the controller.
   cag_ea_if.calc eai
);
   import cag_pkg::*;

   // ************************************************************
   // Address forms
   // ************************************************************
   logic        short_sfr;    // Short field lies in the SFR part of the window.
   logic [15:0] short_addr;   // Short direct address.
   logic [15:0] sfr_addr;     // Special register page address.
   logic [15:0] based_addr;   // Base pair plus unsigned offset.
   logic [15:0] push_addr;    // Stack byte written by a push.
   logic        word_check;   // Word alignment applies to this access.

   // Fields 00H..1FH reach the SFR part, so bit 8 is set for them.
   assign short_sfr  = (eai.field8 < SADDR_SPLIT);
   // Bits 15..9 are all ones so the address never leaves the window.
   assign short_addr = {SADDR_UPPER, short_sfr, eai.field8};
   assign sfr_addr   = {SFR_UPPER, eai.field8};
   // Offset is zero-extended and the carry out of bit 15 is dropped.
   assign based_addr = 16'(eai.base_pair + {8'h00, eai.field8});
   assign push_addr  = 16'(eai.stack_ptr - 16'h0001);

   // Selects the effective address for the requested mode.
   always_comb begin
      case (eai.mode)
         MODE_DIRECT:   eai.ea = eai.imm16;
         MODE_SHORT:    eai.ea = short_addr;
         MODE_SFR:      eai.ea = sfr_addr;
         MODE_IND_PAIR: eai.ea = eai.indirect_pair;
         MODE_IND_BASE: eai.ea = eai.base_pair;
         MODE_BASED:    eai.ea = based_addr;
         MODE_PUSH:     eai.ea = push_addr;
         MODE_POP:      eai.ea = eai.stack_ptr;
         default:       eai.ea = ZERO16;             // Branch and register modes carry no operand address.
      endcase
   end

   // ************************************************************
   // Region and fault flags
   // ************************************************************
   // High-speed RAM and SFR regions of the map.
   assign eai.in_ram = (eai.ea >= RAM_LO) && (eai.ea <= RAM_HI);
   assign eai.in_sfr = (eai.ea >= SFR_LO);
   // Word short operands must sit on an even address pair.
   assign word_check     = eai.word_op && (eai.mode == MODE_SHORT);
   assign eai.misaligned = word_check && eai.ea[0];
   // The stack may only reach internal high-speed RAM.
   assign eai.stack_fault = ((eai.mode == MODE_PUSH) || (eai.mode == MODE_POP)) && !eai.in_ram;

endmodule : cag_ea_calc

// ---- src/cag_addr_gen.sv ----
// Purpose: Branch target and operand address generation for the core.
// Assumes: Decoder and memory run on ref_clk; vector data answers a read.
// Notes:   One request at a time; vector calls take a table read.
module cag_addr_gen (
   // Clock and reset.
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // Request from the instruction decoder.
   input  wire logic                 req_valid,
   output      logic                 req_ready,
   input  wire cag_pkg::cag_mode_type req_mode,
   input  wire logic [7:0]           req_opcode,
   input  wire logic [15:0]          req_imm16,
   input  wire logic [7:0]           req_field8,
   input  wire logic                 req_word,
   input  wire logic [15:0]          req_next_pc,
   // Register file contents.
   input  wire logic [15:0]          accumulator_pair,
   input  wire logic [15:0]          indirect_pair,
   input  wire logic [15:0]          base_pair,
   input  wire logic [15:0]          stack_ptr,
   // Vector table read port.
   output      logic                 vec_rd_en,
   output      logic [15:0]          vec_addr,
   input  wire logic                 vec_rd_valid,
   input  wire logic [15:0]          vec_rd_data,
   // Program counter load.
   output      logic                 pc_load,
   output      logic [15:0]          pc_target,
   // Operand address result.
   output      logic                 ea_valid,
   output      logic [15:0]          ea_addr,
   output      logic                 ea_in_ram,
   output      logic                 ea_in_sfr,
   output      logic                 ea_misaligned,
   output      logic                 ea_stack_fault,
   // Register operand selects.
   output      logic                 reg_valid,
   output      logic [7:0]           reg_sel,
   output      logic [3:0]           pair_sel
);
   import cag_pkg::*;

   // ************************************************************
   // Decode helpers
   // ************************************************************
   // One-hot decode of a 3-bit select, used for registers and pairs.
   function automatic logic [7:0] onehot8(input logic [2:0] idx);
      logic [7:0] res;
      res = 8'h00;
      res[idx] = 1'b1;
      return res;
   endfunction : onehot8

   // Operand modes are all modes that produce a memory address.
   function automatic logic is_operand(input cag_mode_type m);
      logic res;
      res = (m == MODE_DIRECT) || (m == MODE_SHORT) || (m == MODE_SFR) ||
            (m == MODE_IND_PAIR) || (m == MODE_IND_BASE) || (m == MODE_BASED) ||
            (m == MODE_PUSH) || (m == MODE_POP);
      return res;
   endfunction : is_operand

   // ************************************************************
   // Registers and combinational wires
   // ************************************************************
   cag_state_type state_ff;          // Controller state.
   cag_state_type nxt_state;         // Next controller state.
   logic          vec_rd_en_ff;      // One-cycle table read strobe.
   logic [15:0]   vec_addr_ff;       // Table entry address.
   logic          pc_load_ff;        // One-cycle PC load strobe.
   logic [15:0]   pc_target_ff;      // PC value to load.
   logic          ea_valid_ff;       // One-cycle operand strobe.
   logic [15:0]   ea_addr_ff;        // Operand address.
   logic          ea_in_ram_ff;      // Operand region is RAM.
   logic          ea_in_sfr_ff;      // Operand region is SFR page.
   logic          ea_misaligned_ff;  // Word short operand was odd.
   logic          ea_stack_fault_ff; // Stack left the RAM region.
   logic          reg_valid_ff;      // One-cycle register select strobe.
   logic [7:0]    reg_sel_ff;        // One-hot register select.
   logic [3:0]    pair_sel_ff;       // One-hot pair select.

   logic          take;              // Request accepted this cycle.
   logic [15:0]   disp_ext;          // Sign-extended displacement.
   logic [15:0]   rel_target;        // Relative branch target.
   logic [15:0]   vec_entry;         // Table entry address for the opcode.
   logic          branch_now;        // Request is a direct PC load.
   logic [15:0]   branch_target;     // Target of a direct PC load.
   logic [7:0]    pair_hot;          // Wide decode of the pair field.

   cag_ea_if eai ();                 // Link to the operand calculator.

   assign req_ready = (state_ff == ST_IDLE);
   assign take      = req_valid && req_ready;

   // Upper byte copies bit 7 of the displacement.
   assign disp_ext   = {{8{req_field8[7]}}, req_field8};
   assign rel_target = 16'(req_next_pc + disp_ext);
   // Each entry is two bytes, indexed by opcode bits 5..1.
   assign vec_entry  = VEC_TABLE_BASE | {10'h000, req_opcode[VEC_IDX_MSB:VEC_IDX_LSB], 1'b0};

   assign branch_now = (req_mode == MODE_BR_IMM) || (req_mode == MODE_BR_ACC) || (req_mode == MODE_BR_REL);

   // Direct PC sources; vector calls load later from the table.
   always_comb begin
      case (req_mode)
         MODE_BR_IMM: branch_target = req_imm16;
         MODE_BR_ACC: branch_target = accumulator_pair;
         MODE_BR_REL: branch_target = rel_target;
         default:     branch_target = ZERO16;            // Not a direct branch.
      endcase
   end

   assign pair_hot = onehot8({1'b0, req_field8[1:0]});

   // ************************************************************
   // Operand calculator
   // ************************************************************
   assign eai.mode          = req_mode;
   assign eai.field8        = req_field8;
   assign eai.imm16         = req_imm16;
   assign eai.indirect_pair = indirect_pair;
   assign eai.base_pair     = base_pair;
   assign eai.stack_ptr     = stack_ptr;
   assign eai.word_op       = req_word;

   cag_ea_calc u_calc (
      .eai (eai.calc)
   );

   // ************************************************************
   // Controller
   // ************************************************************
   // Vector calls wait for the table word; everything else is one cycle.
   always_comb begin
      case (state_ff)
         ST_IDLE:     nxt_state = (take && req_mode == MODE_VEC_CALL) ? ST_VEC_WAIT : ST_IDLE;
         ST_VEC_WAIT: nxt_state = vec_rd_valid ? ST_IDLE : ST_VEC_WAIT;
         default:     nxt_state = ST_IDLE;
      endcase
   end

   // State and strobes.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff     <= ST_IDLE;
         vec_rd_en_ff <= 1'b0;
         pc_load_ff   <= 1'b0;
         ea_valid_ff  <= 1'b0;
         reg_valid_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         vec_rd_en_ff <= take && (req_mode == MODE_VEC_CALL);
         pc_load_ff   <= (take && branch_now) || ((state_ff == ST_VEC_WAIT) && vec_rd_valid);
         ea_valid_ff  <= take && is_operand(req_mode);
         reg_valid_ff <= take && (req_mode == MODE_REG);
      end
   end

   // Program counter target and table address.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pc_target_ff <= ZERO16;
         vec_addr_ff  <= ZERO16;
      end else begin
         if (take && branch_now) begin
            pc_target_ff <= branch_target;
         end else if ((state_ff == ST_VEC_WAIT) && vec_rd_valid) begin
            pc_target_ff <= vec_rd_data;
         end
         if (take && req_mode == MODE_VEC_CALL) begin
            vec_addr_ff <= vec_entry;
         end
      end
   end

   // Operand address and its region flags, held until the next operand.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ea_addr_ff        <= ZERO16;
         ea_in_ram_ff      <= 1'b0;
         ea_in_sfr_ff      <= 1'b0;
         ea_misaligned_ff  <= 1'b0;
         ea_stack_fault_ff <= 1'b0;
      end else if (take && is_operand(req_mode)) begin
         ea_addr_ff        <= eai.ea;
         ea_in_ram_ff      <= eai.in_ram;
         ea_in_sfr_ff      <= eai.in_sfr;
         ea_misaligned_ff  <= eai.misaligned;
         ea_stack_fault_ff <= eai.stack_fault;
      end
   end

   // Register selects, held until the next register request.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_sel_ff  <= 8'h00;
         pair_sel_ff <= 4'h0;
      end else if (take && req_mode == MODE_REG) begin
         reg_sel_ff  <= onehot8(req_field8[2:0]);
         pair_sel_ff <= pair_hot[3:0];
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign vec_rd_en      = vec_rd_en_ff;
   assign vec_addr       = vec_addr_ff;
   assign pc_load        = pc_load_ff;
   assign pc_target      = pc_target_ff;
   assign ea_valid       = ea_valid_ff;
   assign ea_addr        = ea_addr_ff;
   assign ea_in_ram      = ea_in_ram_ff;
   assign ea_in_sfr      = ea_in_sfr_ff;
   assign ea_misaligned  = ea_misaligned_ff;
   assign ea_stack_fault = ea_stack_fault_ff;
   assign reg_valid      = reg_valid_ff;
   assign reg_sel        = reg_sel_ff;
   assign pair_sel       = pair_sel_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_abs_branch_target: assert property (
      take && req_mode == MODE_BR_IMM |=> pc_load && pc_target == $past(req_imm16))
      else $error("Absolute branch did not load the immediate word.");

   a_vec_table_addr: assert property (
      vec_rd_en |-> vec_addr >= VEC_TABLE_BASE && vec_addr <= VEC_TABLE_LAST && !vec_addr[0])
      else $error("Vector table address outside table or odd.");

   a_vec_pc_load: assert property (
      state_ff == ST_VEC_WAIT && vec_rd_valid |=> pc_load && pc_target == $past(vec_rd_data))
      else $error("Vector call did not load the table word.");

   a_acc_branch: assert property (
      take && req_mode == MODE_BR_ACC |=> pc_target == $past(accumulator_pair))
      else $error("Register branch did not load the accumulator pair.");

   a_rel_sign_fill: assert property (
      take && req_mode == MODE_BR_REL |=>
         pc_target == 16'($past(req_next_pc) + ($past(req_field8[7]) ? {8'hFF, $past(req_field8)}
                                                                     : {8'h00, $past(req_field8)})))
      else $error("Relative target has a wrong sign fill.");

   a_direct_addr: assert property (
      take && req_mode == MODE_DIRECT |=> ea_valid && ea_addr == $past(req_imm16))
      else $error("Direct operand address changed.");

   a_short_window: assert property (
      take && req_mode == MODE_SHORT |=> ea_addr >= RAM_LO && ea_addr <= 16'hFF1F)
      else $error("Short direct address left its window.");

   a_short_bit8: assert property (
      take && req_mode == MODE_SHORT |=> ea_addr[SADDR_BIT8] == ($past(req_field8) < 8'h20))
      else $error("Short direct bit 8 is wrong.");

   a_short_upper: assert property (
      ea_valid && ea_addr[8:0] != 9'h000 && $past(req_mode) == MODE_SHORT |-> ea_addr[15:9] == SADDR_UPPER)
      else $error("Short direct upper bits not all ones.");

   a_word_align: assert property (
      take && req_mode == MODE_SHORT && req_word && req_field8[0] |=> ea_misaligned)
      else $error("Odd word short operand not flagged.");

   a_region_flags: assert property (
      ea_valid |-> ea_in_ram == (ea_addr >= RAM_LO && ea_addr <= RAM_HI) && ea_in_sfr == (ea_addr >= SFR_LO))
      else $error("Operand region flags do not match the address.");

   a_sfr_page: assert property (
      take && req_mode == MODE_SFR |=> ea_addr == {8'hFF, $past(req_field8)} && ea_in_sfr)
      else $error("SFR address not in the FFxxH page.");

   a_reg_onehot: assert property (
      reg_valid |-> $onehot(reg_sel) && $onehot(pair_sel))
      else $error("Register select is not one-hot.");

   a_based_sum: assert property (
      take && req_mode == MODE_BASED |=> ea_addr == 16'($past(base_pair) + {8'h00, $past(req_field8)}))
      else $error("Based address sum is wrong.");

   a_stack_ram: assert property (
      ea_valid && ($past(req_mode) == MODE_PUSH || $past(req_mode) == MODE_POP)
         |-> ea_stack_fault == !(ea_addr >= RAM_LO && ea_addr <= RAM_HI))
      else $error("Stack access outside RAM not flagged.");

   a_vec_wait_bound: assert property (
      vec_rd_en |-> state_ff == ST_VEC_WAIT && !req_ready)
      else $error("Controller accepted a request during a table read.");

endmodule : cag_addr_gen

// ---- sim/cag_vec_mem.sv ----
// Purpose: Vector table memory model that answers table reads.
// Assumes: One table read outstanding at a time.
// Notes:   Data reads as the inverse word whenever no answer stands.
module cag_vec_mem (
   // Clock.
   input  wire logic        ref_clk,
   // Table read from the block.
   input  wire logic        vec_rd_en,
   input  wire logic [15:0] vec_addr,
   input  wire logic [1:0]  lat,
   output      logic        vec_rd_valid,
   output      logic [15:0] vec_rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0]  cnt_ff = 3'h0;  // Cycles left until the answer; zero when idle.
   logic [15:0] word;           // Table word, three times the entry address.
   // Start the wait on a read and count down, so answers come promptly or slowly.
   always_ff @(posedge ref_clk) begin
      if (vec_rd_en) cnt_ff <= {1'b0, lat} + 3'h1;
      else if (cnt_ff != 3'h0) cnt_ff <= cnt_ff - 3'h1;
   end
   assign word         = 16'(vec_addr * 16'h0003);
   assign vec_rd_valid = (cnt_ff == 3'h1);
   assign vec_rd_data  = vec_rd_valid ? word : ~word;
endmodule : cag_vec_mem

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the address generation block.
// Assumes: The vector memory model answers every table read.
// Notes:   Corner fields for every mode first, then random requests.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import cag_pkg::*;
   logic ref_clk, rst_n, rv, rdy, wd, vre, vv, pl, ev, rgv, inr, ins, mis, sf;
   logic [15:0] imm, acc, ind, bas, sp, npc, va, vd, pt, ea, x;
   logic [7:0] op, f8, rs;
   logic [3:0] ps;
   logic [1:0] lat;
   cag_mode_type m;
   int seed = 32'h5fe9, n_errors = 0, checks = 0;
   logic [7:0] crn [8] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h7F, 8'h80, 8'hFE, 8'hFF};
   cag_addr_gen DUT (.ref_clk, .rst_n, .req_valid(rv), .req_ready(rdy), .req_mode(m), .req_opcode(op),
      .req_imm16(imm), .req_field8(f8), .req_word(wd), .req_next_pc(npc), .accumulator_pair(acc),
      .indirect_pair(ind), .base_pair(bas), .stack_ptr(sp), .vec_rd_en(vre), .vec_addr(va),
      .vec_rd_valid(vv), .vec_rd_data(vd), .pc_load(pl), .pc_target(pt), .ea_valid(ev), .ea_addr(ea),
      .ea_in_ram(inr), .ea_in_sfr(ins), .ea_misaligned(mis), .ea_stack_fault(sf), .reg_valid(rgv),
      .reg_sel(rs), .pair_sel(ps));
   cag_vec_mem u_mem (.ref_clk, .vec_rd_en(vre), .vec_addr(va), .lat, .vec_rd_valid(vv), .vec_rd_data(vd));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Compare one value and report a mismatch.
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic conclude;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // Expected address for every mode but the table call and register mode.
   function automatic logic [15:0] exp_addr();
      case (m)
         MODE_BR_IMM, MODE_DIRECT: return imm;
         MODE_BR_ACC:   return acc;
         MODE_BR_REL:   return npc + {{8{f8[7]}}, f8};
         MODE_SHORT:    return {7'h7F, f8 < 8'h20, f8};
         MODE_SFR:      return {8'hFF, f8};
         MODE_IND_PAIR: return ind;
         MODE_IND_BASE: return bas;
         MODE_BASED:    return bas + {8'h00, f8};
         MODE_PUSH:     return sp - 16'h0001;
         default:       return sp;
      endcase
   endfunction : exp_addr
   // Issue one request, then check what it produced.
   task automatic go(input int i);
      int k;
      @(posedge ref_clk);
      m <= cag_mode_type'(i < 104 ? i / 8 : $unsigned($random(seed)) % 13);
      f8 <= i < 104 ? crn[i % 8] : 8'($random(seed));
      sp <= i[0] ? 16'($random(seed)) : 16'hFE21;
      {imm, acc} <= $random(seed);
      {ind, bas} <= $random(seed);
      {npc, op} <= 24'($random(seed));
      {wd, lat} <= 3'($random(seed));
      rv <= 1'b1;
      @(posedge ref_clk);
      rv <= 1'b0;
      #1;
      x = (m == MODE_VEC_CALL) ? (16'h0040 | {10'h000, op[5:1], 1'b0}) : exp_addr();
      if (m == MODE_VEC_CALL) begin
         chk({14'h0, vre, rdy}, 16'h0002);
         chk(va, x);
         for (k = 0; k < 9 && pl !== 1'b1; k++) @(posedge ref_clk) #1;
         chk({15'h0, pl}, 16'h0001);
         chk(pt, 16'(x * 16'h0003));
      end else if (m <= MODE_BR_REL) begin
         chk({15'h0, pl}, 16'h0001);
         chk(pt, x);
      end else if (m == MODE_REG) begin
         chk({3'h0, rgv, ps, rs}, {3'h0, 1'b1, 4'h1 << f8[1:0], 8'h01 << f8[2:0]});
      end else begin
         chk(ea, x);
         chk({12'h0, ev, inr, ins, mis},
             {12'h0, 1'b1, x >= 16'hFE20 && x <= 16'hFEFF, x >= 16'hFF00, m == MODE_SHORT && wd && f8[0]});
         chk({15'h0, sf}, {15'h0, m >= MODE_PUSH && (x < 16'hFE20 || x > 16'hFEFF)});
      end
   endtask : go
   initial begin
      {rst_n, rv, wd, lat, op, f8} = '0;
      {imm, acc, ind, bas, sp, npc} = '0;
      m = MODE_BR_IMM;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk({11'h0, rdy, pl, ev, rgv, vre}, 16'h0010);
      for (int i = 0; i < 600; i++) go(i);
      conclude();
   end
   // Cut a hang short well after the expected run length.
   initial begin
      #(4 * 20000);
      n_errors++;
      conclude();
   end
endmodule : testbench
